// [hw/bus_hold_pkg.sv]
// Shared constants and types of the external bus hold handshake.
// Assumes mclk is the CPU clock that feeds the interface clock dividers.
package bus_hold_pkg;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam logic [1:0] SRC_EXT_CLK = 2'h0;
  localparam logic [1:0] SRC_CPU_DIV4 = 2'h1;
  localparam logic [1:0] SRC_CPU_DIV6 = 2'h2;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam logic [2:0] DIV4_HALF = 3'h2;
  localparam logic [2:0] DIV6_HALF = 3'h3;
  // ----------------------------------------
  // Handshake timing, in interface clock periods
  // ----------------------------------------
  localparam logic [2:0] REDRIVE_TICKS = 3'h2;
  localparam logic [2:0] REDRIVE_MAX_TICKS = 3'h7;
  localparam logic [2:0] GRANT_MAX_TICKS = 3'h2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic GRANT_N_RESET = 1'b1;
  localparam logic BUS_OE_RESET = 1'b1;
  localparam logic REQ_N_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DRAIN, ST_FLOAT, ST_GRANT, ST_REDRIVE, ST_UNGRANT
  } hold_state_t;
endpackage

// [hw/ext_bus_hold_handshake.sv]
// Bus release handshake for one external memory port (wide or narrow).
// Assumes the access engine stops starting accesses while hold_pending is high
// and reports in-flight or queued work on access_busy. Pin tristating is done
// at the pads from the output enables below.
//
// Contract
// - Finish pending and queued accesses before grant.
// - Release inhibit set while draining blocks the grant.
// - Idle bus floats and grants with minimum delay.
// - Float bus outputs first after request.
// - Grant within two interface periods after float.
// - Redrive bus two to seven periods after release.
// - Remove grant within two periods after redrive.
// - Float select chooses clock toggling or floating.
// - Floated clock returns within seven release periods.
// - Wide port floats full group, clock enable.
// - Narrow port floats group, no clock enable.
// - Bus-need output changes after output clock rise.
// - Interface clock from input, CPU/4, CPU/6.
`timescale 1ns/10ps
module ext_bus_hold_handshake
  import bus_hold_pkg::*;
#(
  parameter bit WIDE_PORT = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic bus_hold_req_n,
  input wire logic release_inhibit,
  input wire logic clock_out_float_sel,
  input wire logic [1:0] clk_src_sel,
  input wire logic mem_clock_in,
  input wire logic access_busy,
  input wire logic access_wanted,
  output logic bus_release_grant_n,
  output logic bus_oe,
  output logic sdram_clk_enable_oe,
  output logic mem_clock_out,
  output logic mem_clock_out_oe,
  output logic bus_need_indicator,
  output logic hold_pending
);
  // ----------------------------------------
  // Interface clock generation
  // ----------------------------------------
  logic [2:0] div_cnt_reg;
  logic iclk_reg;
  logic iclk_prev_reg;
  logic tick;
  logic [2:0] div_last;
  logic [2:0] div_half;

  always_comb begin
    div_last = (clk_src_sel == SRC_CPU_DIV6) ? DIV6_LAST : DIV4_LAST;
    div_half = (clk_src_sel == SRC_CPU_DIV6) ? DIV6_HALF : DIV4_HALF;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      div_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (div_cnt_reg >= div_last) begin
        div_cnt_reg <= 3'h0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end

  // External clock input is synchronous to mclk, so it is sampled directly
  always_ff @(posedge mclk) begin
    if (reset) begin
      iclk_reg <= 1'b0;
      iclk_prev_reg <= 1'b0;
    end else if (clk_en) begin
      if (clk_src_sel == SRC_EXT_CLK) begin
        iclk_reg <= mem_clock_in;
      end else begin
        iclk_reg <= (div_cnt_reg < div_half);
      end
      iclk_prev_reg <= iclk_reg;
    end
  end

  // One mclk pulse per interface period, at the output clock's rising edge
  assign tick = clk_en && iclk_reg && !iclk_prev_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_clock_out <= 1'b0;
    end else if (clk_en) begin
      mem_clock_out <= iclk_reg;
    end
  end

  // ----------------------------------------
  // Request synchroniser
  // ----------------------------------------
  logic req_n_meta_reg;
  logic req_n_s2_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      req_n_meta_reg <= REQ_N_RESET;
      req_n_s2_reg <= REQ_N_RESET;
    end else if (clk_en) begin
      req_n_meta_reg <= bus_hold_req_n;
      req_n_s2_reg <= req_n_meta_reg;
    end
  end

  // ----------------------------------------
  // Handshake sequencer
  // ----------------------------------------
  hold_state_t state_reg;
  logic [2:0] tick_cnt_reg;

  // Level sensitive: a request dropped while draining simply aborts the hold
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (!req_n_s2_reg) begin
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (req_n_s2_reg) begin
            state_reg <= ST_IDLE;
          end else if (tick && !access_busy && !release_inhibit) begin
            state_reg <= ST_FLOAT;
          end
        end
        ST_FLOAT: begin
          if (tick) begin
            state_reg <= ST_GRANT;
          end
        end
        ST_GRANT: begin
          // Master keeps the request low a full period past the grant
          if (req_n_s2_reg) begin
            state_reg <= ST_REDRIVE;
          end
        end
        ST_REDRIVE: begin
          // Leave only after REDRIVE_TICKS whole periods past the first tick, so a
          // slow divider can never redrive sooner than the two-period minimum
          if (tick && tick_cnt_reg == REDRIVE_TICKS) begin
            state_reg <= ST_UNGRANT;
          end
        end
        ST_UNGRANT: begin
          if (tick) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (state_reg != ST_REDRIVE) begin
        tick_cnt_reg <= 3'h0;
      end else if (tick) begin
        tick_cnt_reg <= tick_cnt_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Pin control, all from flops
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_oe <= BUS_OE_RESET;
      bus_release_grant_n <= GRANT_N_RESET;
      hold_pending <= 1'b0;
    end else if (clk_en) begin
      // Float before granting; redrive before removing the grant
      bus_oe <= !(state_reg == ST_FLOAT || state_reg == ST_GRANT ||
                  state_reg == ST_REDRIVE) && !(state_reg == ST_DRAIN && tick &&
                  !access_busy && !release_inhibit && !req_n_s2_reg);
      bus_release_grant_n <= !((state_reg == ST_FLOAT && tick) ||
                               state_reg == ST_GRANT || state_reg == ST_REDRIVE ||
                               (state_reg == ST_UNGRANT && !tick));
      hold_pending <= !req_n_s2_reg || state_reg != ST_IDLE;
    end
  end

  // The narrow port has no clock enable pin; its enable is held off
  assign sdram_clk_enable_oe = WIDE_PORT ? bus_oe : 1'b0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_clock_out_oe <= 1'b1;
    end else if (clk_en) begin
      // Tracks the bus enable so the clock returns with the bus
      mem_clock_out_oe <= !clock_out_float_sel ||
                          !(state_reg == ST_FLOAT || state_reg == ST_GRANT ||
                            state_reg == ST_REDRIVE);
    end
  end

  // Updated only on the output clock's rising edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_need_indicator <= 1'b0;
    end else if (tick) begin
      bus_need_indicator <= access_wanted;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [3:0] state_ticks_reg;
  hold_state_t state_prev_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ticks_reg <= 4'h0;
      state_prev_reg <= ST_IDLE;
    end else begin
      state_prev_reg <= state_reg;
      if (state_reg != state_prev_reg) begin
        state_ticks_reg <= 4'h0;
      end else if (tick && state_ticks_reg != 4'hf) begin
        state_ticks_reg <= state_ticks_reg + 4'h1;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  drain_done_a: assert property ($fell(bus_oe) |-> !$past(access_busy))
    else $error("bus floated while accesses pending");
  inhibit_a: assert property ($fell(bus_oe) |-> !$past(release_inhibit))
    else $error("bus released while inhibit set");
  float_first_a: assert property ($fell(bus_release_grant_n) |-> !bus_oe)
    else $error("grant given while bus driven");
  grant_delay_a: assert property (state_prev_reg == ST_FLOAT |->
                                  state_ticks_reg < {1'b0, GRANT_MAX_TICKS})
    else $error("grant later than two periods after float");
  redrive_a: assert property (state_prev_reg == ST_REDRIVE &&
                              state_reg == ST_UNGRANT |->
                              state_ticks_reg >= {1'b0, REDRIVE_TICKS} &&
                              state_ticks_reg <= {1'b0, REDRIVE_MAX_TICKS})
    else $error("redrive outside two to seven periods");
  ungrant_a: assert property ($rose(bus_oe) |-> !bus_release_grant_n)
    else $error("grant removed before bus redriven");
  clk_float_a: assert property (!mem_clock_out_oe |->
                                !bus_oe && $past(clock_out_float_sel))
    else $error("clock floated outside hold");
  need_sync_a: assert property ($changed(bus_need_indicator) |-> $past(tick))
    else $error("bus need changed off clock edge");
  divider_a: assert property (clk_en && clk_src_sel == SRC_CPU_DIV4 |=>
                              div_cnt_reg <= DIV4_LAST)
    else $error("divider counter out of range");
  sync_a: assert property (state_reg == ST_IDLE ##1 state_reg == ST_DRAIN |->
                           !$past(req_n_s2_reg))
    else $error("hold started without synchronised request");

  grant_seen_c: cover property ($fell(bus_release_grant_n));
  hold_done_c: cover property ($rose(bus_release_grant_n) ##1 bus_oe);
  inhibited_c: cover property ((state_reg == ST_DRAIN && release_inhibit) [*4]);
  clk_floated_c: cover property ($fell(mem_clock_out_oe));
endmodule

// [verif/hold_master_model.sv]
// Outside bus master that borrows the memory bus through the hold handshake.
// Assumes the bench raises want to ask for the bus and lowers it to give it back.
`timescale 1ns/10ps
module hold_master_model #(
  parameter int PERIOD_MCLK = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic want,
  input wire logic grant_n,
  output logic req_n
);
  int held;

  // ----------------------------------------
  // Request, level sensitive
  // ----------------------------------------
  // Holds the request at least one interface period once granted
  always @(posedge mclk) begin
    if (reset) begin
      req_n <= 1'b1;
      held <= 0;
    end else begin
      held <= (!req_n && grant_n === 1'b0) ? held + 1 : 0;
      if (want)
        req_n <= 1'b0;
      else if (grant_n !== 1'b0 || held >= PERIOD_MCLK)
        req_n <= 1'b1;
    end
  end
endmodule

// [verif/ext_bus_hold_handshake_bench.sv]
// Self-checking bench of the bus hold handshake, wide port.
// Assumes the partner model drives the request; all else is driven here.
`timescale 1ns/10ps
module ext_bus_hold_handshake_bench;
  import bus_hold_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, want = 1'b0, req_n;
  logic release_inhibit = 1'b0, float_sel = 1'b0, mem_clock_in = 1'b0;
  logic access_busy = 1'b0, access_wanted = 1'b0;
  logic [1:0] src_sel = SRC_CPU_DIV4;
  logic grant_n, bus_oe, sdram_oe, clk_out, clk_oe, need, hold_pending, need_q, clk_q;
  logic narrow_bus_oe, narrow_sdram_oe;
  int n_fail = 0, total_checks = 0, cycles = 0, ext_cnt = 0;

  ext_bus_hold_handshake i_ext_bus_hold_handshake (.mclk(mclk), .reset(reset),
    .clk_en(1'b1), .bus_hold_req_n(req_n), .release_inhibit(release_inhibit),
    .clock_out_float_sel(float_sel), .clk_src_sel(src_sel), .mem_clock_in(mem_clock_in),
    .access_busy(access_busy), .access_wanted(access_wanted),
    .bus_release_grant_n(grant_n), .bus_oe(bus_oe), .sdram_clk_enable_oe(sdram_oe),
    .mem_clock_out(clk_out), .mem_clock_out_oe(clk_oe), .bus_need_indicator(need),
    .hold_pending(hold_pending));
  hold_master_model i_hold_master_model (.mclk(mclk), .reset(reset), .want(want),
    .grant_n(grant_n), .req_n(req_n));
  // Narrow port twin on the same request, watched only for its pin enables
  ext_bus_hold_handshake #(.WIDE_PORT(1'b0)) i_ext_bus_hold_handshake_narrow (.mclk(mclk),
    .reset(reset), .clk_en(1'b1), .bus_hold_req_n(req_n), .release_inhibit(release_inhibit),
    .clock_out_float_sel(float_sel), .clk_src_sel(src_sel), .mem_clock_in(mem_clock_in),
    .access_busy(access_busy), .access_wanted(access_wanted), .bus_release_grant_n(),
    .bus_oe(narrow_bus_oe), .sdram_clk_enable_oe(narrow_sdram_oe), .mem_clock_out(),
    .mem_clock_out_oe(), .bus_need_indicator(), .hold_pending());

  // ----------------------------------------
  // Clock, external interface clock, timeout
  // ----------------------------------------
  initial forever #4 mclk = ~mclk;
  // External clock of six mclk periods, three per phase
  always @(negedge mclk) begin
    ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
    if (ext_cnt == 2) mem_clock_in <= ~mem_clock_in;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      final_report();
    end
  end
  // Bus-need may only move at a rise of the output clock
  always @(negedge mclk) begin
    if (!reset && need !== need_q) check({31'h0, clk_out & ~clk_q}, 32'h1);
    need_q <= need;
    clk_q <= clk_out;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for bus_oe (which=0) or grant_n (which=1) to reach val, bounded
  task automatic wait_until(input int which, input logic val, input int limit, output int n);
    n = 0;
    while ((which == 0 ? bus_oe : grant_n) !== val && n <= limit) begin
      @(negedge mclk);
      n++;
    end
    check({31'h0, n <= limit}, 32'h1);
  endtask

  // One full hold; blk 1 holds accesses busy, blk 2 sets the inhibit first
  task automatic run_hold(input logic [1:0] src, input logic sel, input int per, input int blk);
    int n;
    int tg;
    logic last;
    tg = 0;
    src_sel = src;
    float_sel = sel;
    access_busy = (blk == 1);
    release_inhibit = (blk == 2);
    want = 1'b1;
    if (blk != 0) begin
      repeat (40) @(negedge mclk);
      check({29'h0, hold_pending, bus_oe, grant_n}, 32'h7);
      access_busy = 1'b0;
      release_inhibit = 1'b0;
    end
    wait_until(0, 1'b0, 3 * per + 4, n);
    check(grant_n, 1);
    check(sdram_oe, 0);
    check({30'h0, narrow_bus_oe, narrow_sdram_oe}, 32'h0);
    // The clock pin enable follows the bus enable by one mclk
    @(negedge mclk);
    check(clk_oe, !sel);
    wait_until(1, 1'b0, 2 * per + 1, n);
    last = clk_out;
    repeat (3 * per) begin
      @(negedge mclk);
      // Only a driven pin shows toggles; a floated one shows none
      if (clk_oe && clk_out !== last) tg++;
      last = clk_out;
    end
    check({31'h0, tg > 0}, !sel);
    want = 1'b0;
    wait_until(0, 1'b1, 7 * per + 3, n);
    check({31'h0, n >= 2 * per + 1}, 32'h1);
    check({30'h0, grant_n, clk_oe}, 32'h1);
    wait_until(1, 1'b1, 2 * per + 1, n);
    $display("Hold test done, source %0d, float %0d, blocker %0d", src, sel, blk);
  endtask

  task automatic test_need();
    access_wanted = 1'b1;
    repeat (10) @(negedge mclk);
    check(hold_pending, 0);
    check(need, 1);
    access_wanted = 1'b0;
    repeat (10) @(negedge mclk);
    check(need, 0);
    $display("Bus-need test done");
  endtask

  task automatic final_report();
    $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    check({26'h0, grant_n, bus_oe, clk_oe, sdram_oe, hold_pending, narrow_sdram_oe},
          32'h3c);
    run_hold(SRC_CPU_DIV4, 1'b1, 4, 0);
    run_hold(SRC_CPU_DIV6, 1'b0, 6, 0);
    run_hold(SRC_EXT_CLK, 1'b1, 6, 0);
    run_hold(SRC_CPU_DIV4, 1'b0, 4, 1);
    run_hold(SRC_CPU_DIV6, 1'b1, 6, 2);
    test_need();
    final_report();
  end
endmodule
